// file: src/dtt_demod_in.sv
// demodulator input: pin synchroniser and optional glitch filter
`timescale 1ns/1ps
module dtt_demod_in
    import dtt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // raw pin and filter setup
    input  wire logic       pin,
    input  wire logic       tick,
    input  wire logic [1:0] filt_mode,
    // filtered level
    output logic       level
);
    logic       s1_q;
    logic       s2_q;
    logic       s3_q;
    logic       lvl_q;
    logic       filt_q;
    logic [2:0] fcnt_q;
    logic [2:0] flast;
    logic       use_filt;

    // reserved code 11 runs unfiltered
    assign use_filt = (filt_mode == FILT_4) || (filt_mode == FILT_8);
    assign flast    = (filt_mode == FILT_8) ? FILT8_LAST : FILT4_LAST;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            s3_q   <= 1'b0;
            lvl_q  <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end

    // a new level must hold for the whole window of prescaled ticks
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_q <= 1'b0;
            fcnt_q <= 3'h0;
        end else if (!use_filt || lvl_q == filt_q) begin
            filt_q <= lvl_q;
            fcnt_q <= 3'h0;
        end else if (tick) begin
            if (fcnt_q == flast) begin
                filt_q <= lvl_q;
                fcnt_q <= 3'h0;
            end else begin
                fcnt_q <= fcnt_q + 3'h1;
            end
        end
    end

    assign level = filt_q;
endmodule // dtt_demod_in

// file: src/dtt_pkg.sv
// constants, field positions and codes for the dual timer block
// Overview of operation
// - wide count zero wraps, no timeout
// - first demod edge captures, reloads, starts counting
// - later edges capture complemented count
// - capture sets edge flag, interrupt if enabled
// - after each later capture wide timer reloads full scale
// - hardware swaps enables in alternating mode
// - each terminal count sets timeout bit, except a wide one in the cycle of a demod edge
// - output enable bits route timers to pins
// - combined pin drives AND/OR/NOR/NAND of outputs
// - demod input filter none, four or eight
// - demod edge flags read, write one clears
// - transmit low bits give initial output levels
// - bit six picks demodulator input pin
// - sync mode aligns carrier to wide output
package dtt_pkg;
    // register offsets
    localparam logic [3:0] ADDR_CAR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_SHARED     = 4'h1;
    localparam logic [3:0] ADDR_WIDE_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_SYNC_CTRL  = 4'h3;
    localparam logic [3:0] ADDR_CAR_LO     = 4'h4;
    localparam logic [3:0] ADDR_CAR_HI     = 4'h5;
    localparam logic [3:0] ADDR_WRELOAD_LO = 4'h6;
    localparam logic [3:0] ADDR_WRELOAD_HI = 4'h7;
    localparam logic [3:0] ADDR_CAPT_LO    = 4'h8;
    localparam logic [3:0] ADDR_CAPT_HI    = 4'h9;
    // timer control fields (carrier and wide alike)
    localparam int BIT_EN      = 7;
    localparam int BIT_SPASS   = 6;
    localparam int BIT_TOUT    = 5;
    localparam int BIT_DIV_HI  = 4;
    localparam int BIT_DIV_LO  = 3;
    localparam int BIT_IE      = 2;
    localparam int BIT_OE      = 0;
    // shared control fields
    localparam int BIT_MODE    = 7;
    localparam int BIT_PINSEL  = 6;
    localparam int BIT_B1      = 1;
    localparam int BIT_B0      = 0;
    // sync control fields
    localparam int BIT_SYNC    = 5;
    localparam logic [7:0] RST_CTRL    = 8'h00;
    localparam logic [15:0] FULL_SCALE = 16'hffff;
    localparam logic [15:0] WIDE_TERM  = 16'h0001;
    localparam logic [7:0]  CAR_TERM   = 8'h01;
    // shared bits 3:2 in transmit
    localparam logic [1:0] TX_NORMAL   = 2'b00;
    localparam logic [1:0] TX_ALTERN   = 2'b01;
    localparam logic [1:0] TX_FORCE0   = 2'b10;
    localparam logic [1:0] TX_FORCE1   = 2'b11;
    // shared bits 5:4
    localparam logic [1:0] LOGIC_AND   = 2'b00;
    localparam logic [1:0] LOGIC_OR    = 2'b01;
    localparam logic [1:0] LOGIC_NOR   = 2'b10;
    localparam logic [1:0] EDGE_FALL   = 2'b00;
    localparam logic [1:0] EDGE_RISE   = 2'b01;
    localparam logic [1:0] EDGE_BOTH   = 2'b10;
    // demod filter codes and lengths in prescaled ticks
    localparam logic [1:0] FILT_NONE   = 2'b00;
    localparam logic [1:0] FILT_4      = 2'b01;
    localparam logic [1:0] FILT_8      = 2'b10;
    localparam logic [2:0] FILT4_LAST  = 3'h3;
    localparam logic [2:0] FILT8_LAST  = 3'h7;
    typedef enum logic {DM_WAIT = 1'b0, DM_RUN = 1'b1} dtt_dm_t;
endpackage

// file: src/dtt_prescale.sv
// free running prescaler giving divide by 1, 2, 4 and 8 ticks
`timescale 1ns/1ps
module dtt_prescale
    import dtt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // ticks, index is log2 of the divide
    output logic [3:0] tick
);
    logic [2:0] cnt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 3'h0;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign tick[0] = 1'b1;
    assign tick[1] = cnt_q[0];
    assign tick[2] = &cnt_q[1:0];
    assign tick[3] = &cnt_q[2:0];
endmodule // dtt_prescale

// file: src/dtt_top.sv
// dual carrier and wide timer with transmit and demodulation modes
`timescale 1ns/1ps
module dtt_top
    import dtt_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0] rdata,
    // demodulator input pins
    input  wire logic       demod_in_pin_a,
    input  wire logic       demod_in_pin_b,
    // normal port values used when a pin is not given to a timer
    input  wire logic       port_carrier_val,
    input  wire logic       port_wide_val,
    input  wire logic       port_combined_val,
    // pins
    output logic       carrier_out_pin,
    output logic       wide_out_pin,
    output logic       combined_out_pin,
    // interrupt requests
    output logic       carrier_irq,
    output logic       wide_irq
);
    function automatic logic tick_sel(input logic [1:0] d,
                                      input logic [3:0] t);
        return t[d];
    endfunction

    logic [3:0]  tick;
    logic        demod_lvl;
    // carrier control
    logic        car_en_q, car_sp_q, car_to_q, car_ie_q, car_oe_q;
    logic [1:0]  car_div_q;
    // wide control
    logic        wide_en_q, wide_sp_q, wide_to_q, wide_ie_q, wide_oe_q;
    logic [1:0]  wide_div_q;
    // shared control
    logic        sh_mode_q, sh_d6_q, sh_b1_q, sh_b0_q;
    logic [1:0]  sh_d54_q, sh_d32_q;
    logic        sync_en_q;
    // data registers
    logic [7:0]  car_lo_q, car_hi_q, wrl_q, wrh_q;
    logic [15:0] cap_q;
    // counters and outputs
    logic [7:0]  car_cnt_q;
    logic        car_out_q;
    logic [15:0] wide_cnt_q;
    logic        wide_out_q;
    dtt_dm_t     dm_q;
    logic        lvl_prev_q;
    logic [7:0]  rdata_q;
    logic        car_pin_q, wide_pin_q, comb_pin_q;
    logic        car_irq_q, wide_irq_q;

    dtt_prescale u_pre (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    dtt_demod_in u_dmin (
        .clk       (clk),
        .rst       (rst),
        .pin       (sh_d6_q ? demod_in_pin_b : demod_in_pin_a),
        .tick      (tick_sel(wide_div_q, tick)),
        .filt_mode (sh_d32_q),
        .level     (demod_lvl)
    );

    // write decode
    logic wr_car, wr_sh, wr_wide, wr_sync;
    assign wr_car  = wr && (addr == ADDR_CAR_CTRL);
    assign wr_sh   = wr && (addr == ADDR_SHARED);
    assign wr_wide = wr && (addr == ADDR_WIDE_CTRL);
    assign wr_sync = wr && (addr == ADDR_SYNC_CTRL);

    // mode decode
    logic demod, altern;
    assign demod  = sh_mode_q;
    assign altern = !demod && (sh_d32_q == TX_ALTERN);

    // wide output as seen by the pins, forced levels override the timer
    logic wide_output;
    assign wide_output = (!demod && sh_d32_q == TX_FORCE0) ? 1'b0 :
                         (!demod && sh_d32_q == TX_FORCE1) ? 1'b1 :
                         wide_out_q;

    // carrier held while sync waits for the wide output to rise
    logic car_hold, carrier_output;
    assign car_hold       = sync_en_q && !wide_output;
    assign carrier_output = car_out_q && !car_hold;

    // carrier timer events
    logic car_tick, car_tc, car_done;
    assign car_tick = car_en_q && !car_hold &&
                      tick_sel(car_div_q, tick);
    assign car_tc   = car_tick && (car_cnt_q == CAR_TERM);
    assign car_done = car_tc && car_sp_q;

    // wide timer events in transmit
    logic wide_tick, wide_tc, wide_done;
    assign wide_tick = wide_en_q && tick_sel(wide_div_q, tick);
    // zero is not terminal, it wraps to full scale on the next tick
    assign wide_tc   = wide_tick && (wide_cnt_q == WIDE_TERM);
    assign wide_done = wide_tc && wide_sp_q;

    // starts by software or by the alternating hand over
    logic car_start, wide_start;
    assign car_start  = (wr_car && wdata[BIT_EN] && !car_en_q) ||
                        (altern && wide_done);
    assign wide_start = (wr_wide && wdata[BIT_EN] && !wide_en_q) ||
                        (altern && car_done);

    // demodulator edges and captures
    logic rise, fall, edge_sel, dm_edge, capture;
    assign rise     = demod_lvl && !lvl_prev_q;
    assign fall     = !demod_lvl && lvl_prev_q;
    assign edge_sel = (sh_d54_q == EDGE_FALL) ? fall :
                      (sh_d54_q == EDGE_RISE) ? rise :
                      (sh_d54_q == EDGE_BOTH) ? (rise || fall) : 1'b0;
    assign dm_edge  = demod && wide_en_q && edge_sel;
    // single pass ignores edges after the first
    assign capture  = dm_edge && (dm_q == DM_WAIT || !wide_sp_q);

    // timeout flags: hardware set beats a write-one clear
    logic car_to_d, wide_to_d;
    assign car_to_d  = car_tc ||
                       (car_to_q && !(wr_car && wdata[BIT_TOUT]));
    assign wide_to_d = (wide_tc && !dm_edge) ||
                       (wide_to_q && !(wr_wide && wdata[BIT_TOUT]));

    // low shared bits: initial levels in transmit, edge flags in demod
    logic b1_d, b0_d;
    assign b1_d = demod ? ((capture && rise) ||
                          (sh_b1_q && !(wr_sh && wdata[BIT_B1])))
                        : (wr_sh ? wdata[BIT_B1] : sh_b1_q);
    assign b0_d = demod ? ((capture && fall) ||
                          (sh_b0_q && !(wr_sh && wdata[BIT_B0])))
                        : (wr_sh ? wdata[BIT_B0] : sh_b0_q);

    // enables: hardware stop or hand over wins over a software write
    logic car_en_d, wide_en_d;
    assign car_en_d  = car_start ? 1'b1 :
                       car_done ? 1'b0 :
                       wr_car ? wdata[BIT_EN] : car_en_q;
    assign wide_en_d = wide_start ? 1'b1 :
                       (wide_done && !demod) ? 1'b0 :
                       wr_wide ? wdata[BIT_EN] : wide_en_q;

    // control registers
    always_ff @(posedge clk) begin
        if (rst) begin
            {car_en_q, car_sp_q, car_to_q, car_ie_q, car_oe_q} <= 5'h00;
            {wide_en_q, wide_sp_q, wide_to_q, wide_ie_q, wide_oe_q} <= 5'h00;
            car_div_q  <= 2'b00;
            wide_div_q <= 2'b00;
            {sh_mode_q, sh_d6_q, sh_d54_q, sh_d32_q} <= 6'h00;
            sh_b1_q    <= 1'b0;
            sh_b0_q    <= 1'b0;
            sync_en_q  <= 1'b0;
        end else begin
            car_en_q  <= car_en_d;
            wide_en_q <= wide_en_d;
            car_to_q  <= car_to_d;
            wide_to_q <= wide_to_d;
            sh_b1_q   <= b1_d;
            sh_b0_q   <= b0_d;
            if (wr_car) begin
                car_sp_q  <= wdata[BIT_SPASS];
                car_div_q <= wdata[BIT_DIV_HI:BIT_DIV_LO];
                car_ie_q  <= wdata[BIT_IE];
                car_oe_q  <= wdata[BIT_OE];
            end
            if (wr_wide) begin
                wide_sp_q  <= wdata[BIT_SPASS];
                wide_div_q <= wdata[BIT_DIV_HI:BIT_DIV_LO];
                wide_ie_q  <= wdata[BIT_IE];
                wide_oe_q  <= wdata[BIT_OE];
            end
            if (wr_sh) begin
                sh_mode_q <= wdata[BIT_MODE];
                sh_d6_q   <= wdata[BIT_PINSEL];
                sh_d54_q  <= wdata[5:4];
                sh_d32_q  <= wdata[3:2];
            end
            if (wr_sync) begin
                sync_en_q <= wdata[BIT_SYNC];
            end
        end
    end

    // data registers; a reload write while loading is not protected
    always_ff @(posedge clk) begin
        if (rst) begin
            car_lo_q <= RST_CTRL;
            car_hi_q <= RST_CTRL;
            wrl_q    <= RST_CTRL;
            wrh_q    <= RST_CTRL;
        end else if (wr) begin
            if (addr == ADDR_CAR_LO) car_lo_q <= wdata;
            if (addr == ADDR_CAR_HI) car_hi_q <= wdata;
            if (addr == ADDR_WRELOAD_LO) wrl_q <= wdata;
            if (addr == ADDR_WRELOAD_HI) wrh_q <= wdata;
        end
    end

    // carrier timer: counts high then low time, toggling at each end
    always_ff @(posedge clk) begin
        if (rst) begin
            car_cnt_q <= 8'h00;
            car_out_q <= 1'b0;
        end else if (car_start) begin
            car_out_q <= sh_b1_q;
            car_cnt_q <= sh_b1_q ? car_hi_q : car_lo_q;
        end else if (car_hold) begin
            // start from a fresh high phase so the first pulse is whole
            car_out_q <= 1'b1;
            car_cnt_q <= car_hi_q;
        end else if (car_tc) begin
            car_out_q <= !car_out_q;
            car_cnt_q <= car_out_q ? car_lo_q : car_hi_q;
        end else if (car_tick) begin
            car_cnt_q <= car_cnt_q - 8'h01;
        end
    end

    // wide timer: transmit toggling or demodulation capture
    always_ff @(posedge clk) begin
        if (rst) begin
            wide_cnt_q <= 16'h0000;
            wide_out_q <= 1'b0;
            cap_q      <= 16'h0000;
            dm_q       <= DM_WAIT;
        end else if (wide_start) begin
            wide_cnt_q <= {wrh_q, wrl_q};
            wide_out_q <= demod ? wide_out_q : sh_b0_q;
            dm_q       <= DM_WAIT;
        end else if (demod) begin
            if (capture) begin
                cap_q      <= ~wide_cnt_q;
                dm_q       <= DM_RUN;
                wide_cnt_q <= (dm_q == DM_WAIT) ? {wrh_q, wrl_q}
                                                : FULL_SCALE;
            end else if (dm_q == DM_RUN && wide_tick) begin
                wide_cnt_q <= wide_cnt_q - 16'h0001;
            end
        end else if (wide_tc) begin
            wide_out_q <= !wide_out_q;
            wide_cnt_q <= {wrh_q, wrl_q};
        end else if (wide_tick) begin
            wide_cnt_q <= wide_cnt_q - 16'h0001;
        end
    end

    // pins and interrupt pulses
    logic comb_val;
    assign comb_val = (sh_d54_q == LOGIC_AND) ? (carrier_output & wide_output) :
                      (sh_d54_q == LOGIC_OR)  ? (carrier_output | wide_output) :
                      (sh_d54_q == LOGIC_NOR) ? !(carrier_output | wide_output) :
                      !(carrier_output & wide_output);

    always_ff @(posedge clk) begin
        if (rst) begin
            lvl_prev_q <= 1'b0;
            car_pin_q  <= 1'b0;
            wide_pin_q <= 1'b0;
            comb_pin_q <= 1'b0;
            car_irq_q  <= 1'b0;
            wide_irq_q <= 1'b0;
        end else begin
            lvl_prev_q <= demod_lvl;
            car_pin_q  <= car_oe_q ? carrier_output : port_carrier_val;
            wide_pin_q <= wide_oe_q ? wide_output : port_wide_val;
            comb_pin_q <= (!demod && sh_d6_q) ? comb_val
                                              : port_combined_val;
            car_irq_q  <= car_ie_q && car_tc;
            wide_irq_q <= wide_ie_q && (capture || (wide_tc && !demod));
        end
    end

    // read mux, data valid the cycle after the strobe only
    logic [7:0] rd_car, rd_sh, rd_wide, rd_sync, rd_mux;
    assign rd_car  = {car_en_q, car_sp_q, car_to_q, car_div_q,
                      car_ie_q, 1'b0, car_oe_q};
    assign rd_wide = {wide_en_q, wide_sp_q, wide_to_q, wide_div_q,
                      wide_ie_q, 1'b0, wide_oe_q};
    assign rd_sh   = {sh_mode_q, sh_d6_q, sh_d54_q, sh_d32_q,
                      sh_b1_q, sh_b0_q};
    assign rd_sync = {wide_en_q, car_en_q, sync_en_q, 5'h00};
    assign rd_mux  = (addr == ADDR_CAR_CTRL)   ? rd_car :
                     (addr == ADDR_SHARED)     ? rd_sh :
                     (addr == ADDR_WIDE_CTRL)  ? rd_wide :
                     (addr == ADDR_SYNC_CTRL)  ? rd_sync :
                     (addr == ADDR_CAR_LO)     ? car_lo_q :
                     (addr == ADDR_CAR_HI)     ? car_hi_q :
                     (addr == ADDR_WRELOAD_LO) ? wrl_q :
                     (addr == ADDR_WRELOAD_HI) ? wrh_q :
                     (addr == ADDR_CAPT_LO)    ? cap_q[7:0] :
                     (addr == ADDR_CAPT_HI)    ? cap_q[15:8] : 8'h00;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd ? rd_mux : 8'h00;
        end
    end

    assign rdata            = rdata_q;
    assign carrier_out_pin  = car_pin_q;
    assign wide_out_pin     = wide_pin_q;
    assign combined_out_pin = comb_pin_q;
    assign carrier_irq      = car_irq_q;
    assign wide_irq         = wide_irq_q;
endmodule // dtt_top

// file: verif/dtt_sig_src.sv
// partner model: square wave source on both demodulator pins
`timescale 1ns/1ps
module dtt_sig_src (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       run,
    input  wire logic [7:0] half_a,
    input  wire logic [7:0] half_b,
    // pins
    output logic            pin_a,
    output logic            pin_b
);
    logic [7:0] cnt_a_q;
    logic [7:0] cnt_b_q;
    // stopped source holds its level, so no stray edge reaches the block
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_a <= 1'b0;
            pin_b <= 1'b0;
        end
        if (rst || !run) begin
            cnt_a_q <= 8'h00;
            cnt_b_q <= 8'h00;
        end else begin
            cnt_a_q <= (cnt_a_q == half_a - 8'h01) ? 8'h00 : cnt_a_q + 8'h01;
            cnt_b_q <= (cnt_b_q == half_b - 8'h01) ? 8'h00 : cnt_b_q + 8'h01;
            if (cnt_a_q == half_a - 8'h01) pin_a <= ~pin_a;
            if (cnt_b_q == half_b - 8'h01) pin_b <= ~pin_b;
        end
    end
endmodule // dtt_sig_src

// file: verif/dtt_top_chk.sv
// assertion checker bound to the dual timer top
`timescale 1ns/1ps
module dtt_top_chk
    import dtt_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // port values and pins
    input wire logic       port_carrier_val,
    input wire logic       port_wide_val,
    input wire logic       port_combined_val,
    input wire logic       carrier_out_pin,
    input wire logic       wide_out_pin,
    input wire logic       combined_out_pin,
    // interrupt
    input wire logic       wide_irq
);
    logic       oe_c_q;
    logic       oe_w_q;
    logic       cmb_q;
    logic       ie_w_q;
    logic [1:0] lg_q;
    wire        wr_c = wr && addr == ADDR_CAR_CTRL;
    wire        wr_w = wr && addr == ADDR_WIDE_CTRL;
    wire        wr_s = wr && addr == ADDR_SHARED;
    // shadow of bits that only software changes
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_c_q <= 1'b0;
            oe_w_q <= 1'b0;
            cmb_q  <= 1'b0;
            ie_w_q <= 1'b0;
            lg_q   <= 2'b00;
        end else begin
            if (wr_c) oe_c_q <= wdata[BIT_OE];
            if (wr_w) oe_w_q <= wdata[BIT_OE];
            if (wr_w) ie_w_q <= wdata[BIT_IE];
            if (wr_s) cmb_q <= !wdata[BIT_MODE] && wdata[BIT_PINSEL];
            if (wr_s) lg_q <= wdata[5:4];
        end
    end
    // nor and nand are or and and inverted by the upper code bit
    function automatic logic comb(logic [1:0] c, logic a, logic b);
        return ((c[0] ^ c[1]) ? (a | b) : (a & b)) ^ c[1];
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rst_zero;
        $fell(rst) |-> rdata == 8'h00 && !wide_irq && !carrier_out_pin
            && !wide_out_pin && !combined_out_pin;
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("outputs not zero after reset");
    property p_rd_idle;
        !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read");
    property p_car_port;
        !$past(rst) && !$past(oe_c_q)
            |-> carrier_out_pin == $past(port_carrier_val);
    endproperty
    a_car_port: assert property (p_car_port)
        else $error("carrier pin not port value");
    property p_wide_port;
        !$past(rst) && !$past(oe_w_q) |-> wide_out_pin == $past(port_wide_val);
    endproperty
    a_wide_port: assert property (p_wide_port)
        else $error("wide pin not port value");
    property p_cmb_port;
        !$past(rst) && !$past(cmb_q)
            |-> combined_out_pin == $past(port_combined_val);
    endproperty
    a_cmb_port: assert property (p_cmb_port)
        else $error("combined pin not port value");
    property p_cmb_logic;
        !$past(rst) && $past(cmb_q && oe_c_q && oe_w_q) |-> combined_out_pin
            == comb($past(lg_q), carrier_out_pin, wide_out_pin);
    endproperty
    a_cmb_logic: assert property (p_cmb_logic)
        else $error("combined pin wrong logic");
    property p_irq_mask;
        !ie_w_q && !$past(ie_w_q) && !$past(ie_w_q, 2) |-> !wide_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("wide interrupt while disabled");
    property p_irq_pulse;
        wide_irq |=> !wide_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("wide interrupt longer than one cycle");
endmodule // dtt_top_chk

bind dtt_top dtt_top_chk dtt_top_chk_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port_carrier_val(port_carrier_val),
    .port_wide_val(port_wide_val), .port_combined_val(port_combined_val),
    .carrier_out_pin(carrier_out_pin), .wide_out_pin(wide_out_pin),
    .combined_out_pin(combined_out_pin), .wide_irq(wide_irq)
);

// file: verif/testbench.sv
// self-checking testbench for the dual timer block
`timescale 1ns/1ps
module testbench
    import dtt_pkg::*;
;
    logic        clk, rst, wr, rd, run, rd_d;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, half_a, half_b;
    logic        pin_a, pin_b, pv_c, pv_w, pv_k;
    logic        car_pin, wide_pin, cmb_pin, car_irq, wide_irq;
    logic [31:0] seed;
    logic [7:0]  exp_q[$];
    int          failures, samples_checked;

    dtt_top dtt_top_i (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .demod_in_pin_a(pin_a), .demod_in_pin_b(pin_b),
        .port_carrier_val(pv_c), .port_wide_val(pv_w),
        .port_combined_val(pv_k), .carrier_out_pin(car_pin),
        .wide_out_pin(wide_pin), .combined_out_pin(cmb_pin),
        .carrier_irq(car_irq), .wide_irq(wide_irq)
    );
    dtt_sig_src dtt_sig_src_i (
        .clk(clk), .rst(rst), .run(run), .half_a(half_a), .half_b(half_b),
        .pin_a(pin_a), .pin_b(pin_b)
    );

    always #12.5 clk = ~clk;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // random port values keep the pass-through paths busy
    always @(posedge clk) begin
        seed <= lfsr(seed);
        {pv_c, pv_w, pv_k} <= seed[2:0];
    end

    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (e !== g) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(logic [3:0] a, logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(logic [3:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        rd   <= 1'b0;
    endtask
    // waits for a wide interrupt, or a wide pin change; n is the cycles
    task automatic wait_ev(logic irq, output int n);
        logic v;
        v = wide_pin;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((irq ? wide_irq !== 1'b1 : wide_pin === v) && n < 400);
        if (n >= 400) begin
            failures++;
            stop_test();
        end
    endtask

    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            chk("rdata", 16'(exp_q[0]), 16'(rdata));
            void'(exp_q.pop_front());
        end
    end

    initial begin
        int n, g, h;
        logic [7:0] cfg;
        {clk, wr, rd, run, rd_d, addr, wdata, half_a, half_b} = '0;
        rst = 1'b1;
        seed = 32'h57eb;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd_reg(4'(a), 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr_reg(ADDR_WIDE_CTRL, 8'h00);
            wr_reg(ADDR_SHARED, {7'h00, k[0]});
            wr_reg(ADDR_WRELOAD_LO, 8'h03);
            wr_reg(ADDR_WIDE_CTRL, 8'h81 | 8'(k << 3));
            repeat (2) @(negedge clk);
            chk("init", 16'(k[0]), 16'(wide_pin));
            wait_ev(1'b0, n);
            wait_ev(1'b0, n);
            chk("period", 16'(3 << k), 16'(n));
        end
        wr_reg(ADDR_CAR_LO, 8'h02);
        wr_reg(ADDR_CAR_HI, 8'h03);
        wr_reg(ADDR_CAR_CTRL, 8'h85);
        for (int c = 0; c < 4; c++) begin
            wr_reg(ADDR_SHARED, 8'h40 | 8'(c << 4));
            repeat (20) @(posedge clk);
        end
        wr_reg(ADDR_CAR_CTRL, 8'h00);
        wr_reg(ADDR_WIDE_CTRL, 8'h00);
        wr_reg(ADDR_SHARED, 8'h00);
        wr_reg(ADDR_WRELOAD_LO, 8'h05);
        wr_reg(ADDR_WIDE_CTRL, 8'hc5);
        wait_ev(1'b1, n);
        rd_reg(ADDR_WIDE_CTRL, 8'h65);
        wr_reg(ADDR_WIDE_CTRL, 8'h65);
        rd_reg(ADDR_WIDE_CTRL, 8'h45);
        wr_reg(ADDR_SHARED, 8'h04);
        wr_reg(ADDR_CAR_CTRL, 8'hc4);
        repeat (3) @(negedge clk);
        chk("car_irq", 16'h1, 16'(car_irq));
        rd_reg(ADDR_SYNC_CTRL, 8'h80);
        wr_reg(ADDR_SHARED, 8'h0c);
        repeat (2) @(negedge clk);
        chk("forced", 16'h1, 16'(wide_pin));
        // e picks edge code, filter code and input pin together
        for (int e = 0; e < 3; e++) begin
            g = 16 + int'(seed[4:0]);
            half_a <= 8'(g);
            half_b <= 8'(g + 5);
            cfg = 8'h80 | 8'(e << 2) | 8'(e << 4) | 8'(e[0] << 6);
            wr_reg(ADDR_WIDE_CTRL, 8'h00);
            wr_reg(ADDR_WRELOAD_LO, 8'hff);
            wr_reg(ADDR_WRELOAD_HI, 8'hff);
            wr_reg(ADDR_SHARED, cfg);
            // pin and filter switch settle while the timer is off
            repeat (16) @(posedge clk);
            wr_reg(ADDR_WIDE_CTRL, 8'h84);
            run <= 1'b1;
            wait_ev(1'b1, n);
            wait_ev(1'b1, n);
            h = e[0] ? g + 5 : g;
            h = (e == 2) ? h - 1 : 2 * h - 1;
            rd_reg(ADDR_CAPT_LO, h[7:0]);
            rd_reg(ADDR_CAPT_HI, h[15:8]);
            rd_reg(ADDR_SHARED, cfg | 8'(e + 1));
            run <= 1'b0;
            repeat (30) @(posedge clk);
            wr_reg(ADDR_SHARED, cfg | 8'h03);
            rd_reg(ADDR_SHARED, cfg);
        end
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule // testbench
